/* File: inc/dwf_pkg.sv */
// Shared constants for the waveform memory and sequencer.
// Assumes one core clock domain; the serial port pins are asynchronous.
package dwf_pkg;

  // Waveform storage geometry
  localparam int WORD_W = 12;
  localparam int DEPTH = 16;
  localparam int ADDR_W = 4;
  localparam int POS_W = 5;
  localparam int IDX_W = 6;

  // Serial frame: command byte, then data bytes; bit 7 of the command marks a read
  localparam int CMD_RD_BIT = 7;
  localparam logic [6:0] REG_CTRL = 7'h01;
  localparam logic [6:0] REG_DAC_IN = 7'h02;
  localparam logic [6:0] REG_WORD_PORT = 7'h03;
  localparam logic [6:0] REG_STEP = 7'h04;

  // Byte index of the step frame's only data byte (ends on the 16th edge)
  localparam logic [IDX_W-1:0] STEP_BYTE_IDX = 6'h01;
  localparam logic [IDX_W-1:0] IDX_MAX = 6'h3F;

  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_BIP_BIT = 6;
  localparam int CTRL_SYM_BIT = 5;
  localparam int CTRL_CON_BIT = 4;
  localparam int CTRL_DEPTH_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Word layout inside a 16-bit frame: value on top, low nibble ignored
  localparam int WORD_LSB = 4;
  localparam logic [WORD_W-1:0] DAC_IN_RESET = 12'h000;
  localparam logic [WORD_W-1:0] DAC_OUT_RESET = 12'h000;
  localparam logic [WORD_W-1:0] DAC_FULL_SCALE = 12'hFFF;

  // Sequencer phases
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_UP_ADD = 3'b001,
    SEQ_DN_ADD = 3'b010,
    SEQ_UP_SUB = 3'b011,
    SEQ_DN_SUB = 3'b100,
    SEQ_DONE = 3'b101
  } dwf_seq_t;

endpackage

/* File: src/dwf_wave_mem.sv */
// Sixteen-word waveform store with one write and two read ports.
// Assumes writes and reads come from the same core clock domain.
`timescale 1ns/1ns
`default_nettype none
module dwf_wave_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [dwf_pkg::ADDR_W-1:0] waddr,
  input wire logic [dwf_pkg::WORD_W-1:0] wdata,
  input wire logic [dwf_pkg::ADDR_W-1:0] raddr_a,
  output logic [dwf_pkg::WORD_W-1:0] rdata_a,
  input wire logic [dwf_pkg::ADDR_W-1:0] raddr_b,
  output logic [dwf_pkg::WORD_W-1:0] rdata_b
);

  // No reset: contents are undefined until software fills them
  logic [dwf_pkg::WORD_W-1:0] mem [dwf_pkg::DEPTH];

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Asynchronous reads so the serial reply and the sequencer see data at once
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule
`default_nettype wire

/* File: src/dwf_serial_port.sv */
// Byte-level serial slave: samples the serial clock on the core clock.
// Assumes the serial clock is far slower than the core clock (8x or more).
`timescale 1ns/1ns
`default_nettype none
module dwf_serial_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [7:0] tx_byte,
  output logic byte_stb,
  output logic [7:0] rx_byte,
  output logic [dwf_pkg::IDX_W-1:0] byte_idx,
  output logic dout
);

  logic sclk_m_r, sclk_s_r, sclk_d_r;
  logic cs_m_r, cs_s_r, din_m_r, din_s_r;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, rxb_r, rxb_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [dwf_pkg::IDX_W-1:0] idx_r, idx_nxt, idxo_r, idxo_nxt;
  logic stb_r, stb_nxt, dout_r, dout_nxt;
  logic rise, fall;

  // Two-stage synchronisers; first stages feed only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
    end else begin
      sclk_m_r <= sclk;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      cs_m_r <= cs_n;
      cs_s_r <= cs_m_r;
      din_m_r <= din;
      din_s_r <= din_m_r;
    end
  end

  assign rise = sclk_s_r & ~sclk_d_r & ~cs_s_r;
  assign fall = ~sclk_s_r & sclk_d_r & ~cs_s_r;

  // Shift in on rising edges, out on falling edges
  always_comb begin
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    rxb_nxt = rxb_r;
    bit_nxt = bit_r;
    idx_nxt = idx_r;
    idxo_nxt = idxo_r;
    stb_nxt = 1'b0;
    dout_nxt = dout_r;
    if (cs_s_r) begin
      // Deselect ends the frame and clears any partial byte
      bit_nxt = 3'h0;
      idx_nxt = '0;
      tx_nxt = 8'h00;
      dout_nxt = 1'b0;
    end else begin
      if (rise) begin
        sh_nxt = {sh_r[6:0], din_s_r};
        bit_nxt = bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          stb_nxt = 1'b1;
          rxb_nxt = {sh_r[6:0], din_s_r};
          idxo_nxt = idx_r;
          idx_nxt = (idx_r == dwf_pkg::IDX_MAX) ? idx_r : idx_r + 6'h01;
        end
      end
      // Reply byte is ready one cycle after the strobe, well before the next fall
      if (stb_r) begin
        tx_nxt = tx_byte;
      end
      if (fall) begin
        dout_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      rxb_r <= 8'h00;
      bit_r <= 3'h0;
      idx_r <= '0;
      idxo_r <= '0;
      stb_r <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      rxb_r <= rxb_nxt;
      bit_r <= bit_nxt;
      idx_r <= idx_nxt;
      idxo_r <= idxo_nxt;
      stb_r <= stb_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign byte_stb = stb_r;
  assign rx_byte = rxb_r;
  assign byte_idx = idxo_r;
  assign dout = dout_r;

endmodule
`default_nettype wire

/* File: src/dwf_sequencer.sv */
// Waveform memory, control registers and step sequencer for the first DAC.
// Assumes a serial host on SCLK/CS_N/DIN/DOUT and a load pin from outside.
`timescale 1ns/1ns
`default_nettype none
module dwf_sequencer (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  input wire logic LOAD_PIN,
  input wire logic DAC_A_LOAD_PIN_MODE,
  input wire logic DAC_BOTH_LOAD_PIN_MODE,
  output logic [dwf_pkg::WORD_W-1:0] DAC_OUT,
  output logic DAC_OUT_LOAD
);

  logic byte_stb;
  logic [7:0] rx_byte, tx_byte;
  logic [dwf_pkg::IDX_W-1:0] byte_idx;
  logic [7:0] cmd_r, cmd_nxt, hi_r, hi_nxt, ctrl_r, ctrl_nxt;
  logic [dwf_pkg::WORD_W-1:0] dac_in_r, dac_in_nxt, dac_out_r, dac_out_nxt;
  logic [dwf_pkg::POS_W-1:0] ptr_r, ptr_nxt, rd_ptr, pos_r, pos_nxt, n_loc;
  dwf_pkg::dwf_seq_t ph_r, ph_nxt;
  logic load_r, load_nxt;
  logic pin_m_r, pin_s_r, pin_d_r;
  logic mem_we, is_rd, word_done, ctrl_wr, ctrl_chg, ser_step, pin_step, step;
  logic [dwf_pkg::WORD_W-1:0] rd_word, seq_word;
  logic [15:0] reply;
  logic signed [14:0] term, sum;
  logic enable, bip, sym, con;

  // Serial slave and waveform store
  dwf_serial_port u_port (
    .clk(CORE_CLK),
    .rst(RST),
    .sclk(SCLK),
    .cs_n(CS_N),
    .din(DIN),
    .tx_byte(tx_byte),
    .byte_stb(byte_stb),
    .rx_byte(rx_byte),
    .byte_idx(byte_idx),
    .dout(DOUT)
  );

  dwf_wave_mem u_mem (
    .clk(CORE_CLK),
    .we(mem_we),
    .waddr(ptr_r[dwf_pkg::ADDR_W-1:0]),
    .wdata({hi_r, rx_byte[7:dwf_pkg::WORD_LSB]}),
    .raddr_a(rd_ptr[dwf_pkg::ADDR_W-1:0]),
    .rdata_a(rd_word),
    .raddr_b(pos_nxt[dwf_pkg::ADDR_W-1:0] - 4'h1),
    .rdata_b(seq_word)
  );

  assign enable = ctrl_r[dwf_pkg::CTRL_EN_BIT];
  assign bip = ctrl_r[dwf_pkg::CTRL_BIP_BIT];
  assign sym = ctrl_r[dwf_pkg::CTRL_SYM_BIT];
  assign con = ctrl_r[dwf_pkg::CTRL_CON_BIT];
  assign n_loc = {1'b0, ctrl_r[dwf_pkg::CTRL_DEPTH_LSB +: 4]} + 5'h01;

  // Frame decode; reads never change state, so a step read is inert
  assign is_rd = cmd_r[dwf_pkg::CMD_RD_BIT];
  assign word_done = byte_stb && byte_idx >= 6'h02 && !byte_idx[0];
  assign mem_we = word_done && !is_rd && cmd_r[6:0] == dwf_pkg::REG_WORD_PORT
                  && !enable && ptr_r < n_loc;
  assign ctrl_wr = byte_stb && !is_rd && byte_idx == 6'h01
                   && cmd_r[6:0] == dwf_pkg::REG_CTRL;
  assign ctrl_chg = ctrl_wr && rx_byte != ctrl_r;
  // Second byte of a step write completes on the 16th rising edge
  assign ser_step = byte_stb && !is_rd && byte_idx == dwf_pkg::STEP_BYTE_IDX
                    && cmd_r[6:0] == dwf_pkg::REG_STEP;
  assign pin_step = pin_s_r && !pin_d_r
                    && (DAC_A_LOAD_PIN_MODE || DAC_BOTH_LOAD_PIN_MODE);
  assign step = (ser_step || pin_step) && enable && ph_r != dwf_pkg::SEQ_DONE;

  // Reply data: the word index moves on as soon as a word has been clocked out
  always_comb begin
    rd_ptr = ptr_r;
    if (byte_idx == 6'h00) begin
      rd_ptr = 5'h00;
    end else if (word_done && ptr_r != 5'h10) begin
      rd_ptr = ptr_r + 5'h01;
    end
    reply = 16'h0000;
    unique case (cmd_r[6:0])
      dwf_pkg::REG_CTRL: reply = {ctrl_r, 8'h00};
      dwf_pkg::REG_DAC_IN: reply = {dac_in_r, 4'h0};
      dwf_pkg::REG_WORD_PORT: reply = (rd_ptr < n_loc) ? {rd_word, 4'h0} : 16'h0000;
      default: reply = 16'h0000;
    endcase
    // Command byte sets the register; even bytes send high halves
    if (byte_idx == 6'h00) begin
      unique case (rx_byte[6:0])
        dwf_pkg::REG_CTRL: tx_byte = ctrl_r;
        dwf_pkg::REG_DAC_IN: tx_byte = dac_in_r[11:4];
        dwf_pkg::REG_WORD_PORT: tx_byte = {rd_word[11:4]};
        default: tx_byte = 8'h00;
      endcase
    end else if (cmd_r[6:0] == dwf_pkg::REG_CTRL) begin
      tx_byte = 8'h00;
    end else begin
      tx_byte = byte_idx[0] ? reply[7:0] : reply[15:8];
    end
  end

  // Register and burst-pointer updates from the serial port
  always_comb begin
    cmd_nxt = cmd_r;
    hi_nxt = hi_r;
    ctrl_nxt = ctrl_r;
    dac_in_nxt = dac_in_r;
    ptr_nxt = ptr_r;
    if (byte_stb) begin
      if (byte_idx == 6'h00) begin
        cmd_nxt = rx_byte;
        ptr_nxt = 5'h00;
      end else if (byte_idx[0]) begin
        hi_nxt = rx_byte;
      end
      if (word_done && ptr_r != 5'h10) begin
        ptr_nxt = ptr_r + 5'h01;
      end
      if (ctrl_wr) begin
        ctrl_nxt = rx_byte;
      end
      if (!is_rd && byte_idx == 6'h02 && cmd_r[6:0] == dwf_pkg::REG_DAC_IN) begin
        dac_in_nxt = {hi_r, rx_byte[7:4]};
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cmd_r <= 8'h00;
      hi_r <= 8'h00;
      ctrl_r <= dwf_pkg::CTRL_RESET;
      dac_in_r <= dwf_pkg::DAC_IN_RESET;
      ptr_r <= 5'h00;
      pin_m_r <= 1'b0;
      pin_s_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      hi_r <= hi_nxt;
      ctrl_r <= ctrl_nxt;
      dac_in_r <= dac_in_nxt;
      ptr_r <= ptr_nxt;
      pin_m_r <= LOAD_PIN;
      pin_s_r <= pin_m_r;
      pin_d_r <= pin_s_r;
    end
  end

  // Phase walk: up through the words, optionally back down, then the negative half when bipolar
  always_comb begin
    ph_nxt = ph_r;
    pos_nxt = pos_r;
    if (ctrl_chg) begin
      ph_nxt = dwf_pkg::SEQ_IDLE;
      pos_nxt = 5'h00;
    end else if (step) begin
      unique case (ph_r)
        dwf_pkg::SEQ_IDLE: begin
          ph_nxt = dwf_pkg::SEQ_UP_ADD;
          pos_nxt = 5'h00;
        end
        dwf_pkg::SEQ_UP_ADD: begin
          if (pos_r < n_loc) begin
            pos_nxt = pos_r + 5'h01;
          end else if (sym) begin
            ph_nxt = dwf_pkg::SEQ_DN_ADD;
            pos_nxt = n_loc - 5'h01;
          end else if (bip) begin
            ph_nxt = dwf_pkg::SEQ_DN_SUB;
            pos_nxt = n_loc;
          end else begin
            ph_nxt = con ? dwf_pkg::SEQ_UP_ADD : dwf_pkg::SEQ_DONE;
            pos_nxt = con ? 5'h00 : pos_r;
          end
        end
        dwf_pkg::SEQ_DN_ADD: begin
          if (pos_r != 5'h00) begin
            pos_nxt = pos_r - 5'h01;
          end else if (bip) begin
            ph_nxt = dwf_pkg::SEQ_UP_SUB;
            pos_nxt = 5'h01;
          end else begin
            ph_nxt = con ? dwf_pkg::SEQ_UP_ADD : dwf_pkg::SEQ_DONE;
            pos_nxt = con ? 5'h01 : pos_r;
          end
        end
        dwf_pkg::SEQ_UP_SUB: begin
          if (pos_r < n_loc) begin
            pos_nxt = pos_r + 5'h01;
          end else begin
            ph_nxt = dwf_pkg::SEQ_DN_SUB;
            pos_nxt = n_loc - 5'h01;
          end
        end
        dwf_pkg::SEQ_DN_SUB: begin
          if (pos_r != 5'h00) begin
            pos_nxt = pos_r - 5'h01;
          end else begin
            ph_nxt = con ? dwf_pkg::SEQ_UP_ADD : dwf_pkg::SEQ_DONE;
            pos_nxt = con ? 5'h01 : pos_r;
          end
        end
        default: begin
          ph_nxt = dwf_pkg::SEQ_IDLE;
          pos_nxt = 5'h00;
        end
      endcase
    end
  end

  // Output value; clamped so a large offset cannot wrap around the scale
  always_comb begin
    if (pos_nxt == 5'h00) begin
      term = 15'sh0000;
    end else if (!bip) begin
      term = $signed({3'b000, seq_word});
    end else if (seq_word[11]) begin
      term = -$signed({4'b0000, seq_word[10:0]});
    end else begin
      term = $signed({4'b0000, seq_word[10:0]});
    end
    if (ph_nxt == dwf_pkg::SEQ_UP_SUB || ph_nxt == dwf_pkg::SEQ_DN_SUB) begin
      term = -term;
    end
    sum = $signed({3'b000, dac_in_r}) + term;
    dac_out_nxt = dac_out_r;
    load_nxt = 1'b0;
    if (step && !ctrl_chg && ph_nxt != dwf_pkg::SEQ_DONE) begin
      load_nxt = 1'b1;
      if (sum < 0) begin
        dac_out_nxt = 12'h000;
      end else if (sum > $signed({3'b000, dwf_pkg::DAC_FULL_SCALE})) begin
        dac_out_nxt = dwf_pkg::DAC_FULL_SCALE;
      end else begin
        dac_out_nxt = sum[11:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ph_r <= dwf_pkg::SEQ_IDLE;
      pos_r <= 5'h00;
      dac_out_r <= dwf_pkg::DAC_OUT_RESET;
      load_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      pos_r <= pos_nxt;
      dac_out_r <= dac_out_nxt;
      load_r <= load_nxt;
    end
  end

  assign DAC_OUT = dac_out_r;
  assign DAC_OUT_LOAD = load_r;

  // Checks on the storage port and the step frame
  a_write_locked: assert property (@(posedge CORE_CLK) disable iff (RST)
    mem_we |-> !ctrl_r[dwf_pkg::CTRL_EN_BIT]) else $error("word written while enabled");
  a_write_in_depth: assert property (@(posedge CORE_CLK) disable iff (RST)
    mem_we |-> ptr_r <= {1'b0, ctrl_r[3:0]}) else $error("word written past depth");
  a_read_past_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
    (byte_stb && is_rd && cmd_r[6:0] == dwf_pkg::REG_WORD_PORT && byte_idx != 6'h00
     && rd_ptr > {1'b0, ctrl_r[3:0]}) |-> tx_byte == 8'h00) else $error("read past depth not zero");
  a_step_sixteenth: assert property (@(posedge CORE_CLK) disable iff (RST)
    ser_step |-> u_port.idx_r == 6'h02 && u_port.bit_r == 3'h0) else $error("step not on 16th edge");
  // Checks on the sequencer
  a_ctrl_restart: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctrl_chg |=> ph_r == dwf_pkg::SEQ_IDLE && pos_r == 5'h00) else $error("no restart");
  a_first_is_input: assert property (@(posedge CORE_CLK) disable iff (RST)
    (step && ph_r == dwf_pkg::SEQ_IDLE && !ctrl_chg) |=> DAC_OUT == $past(dac_in_r) && DAC_OUT_LOAD)
    else $error("first output not the input value");
  a_idle_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    ((ser_step || pin_step) && (!enable || ph_r == dwf_pkg::SEQ_DONE)) |=> $stable(DAC_OUT) && !DAC_OUT_LOAD)
    else $error("ignored step changed output");
  a_pos_in_range: assert property (@(posedge CORE_CLK) disable iff (RST)
    pos_r <= {1'b0, ctrl_r[3:0]} + 5'h01 || $past(ctrl_wr)) else $error("position past depth");
  a_unipolar_add: assert property (@(posedge CORE_CLK) disable iff (RST)
    (step && !ctrl_chg && !bip && ph_nxt == dwf_pkg::SEQ_UP_ADD && pos_nxt != 5'h00
     && {1'b0, dac_in_r} + {1'b0, seq_word} < 13'h1000)
    |=> DAC_OUT == $past(dac_in_r) + $past(seq_word)) else $error("unipolar sum wrong");

endmodule
`default_nettype wire

/* File: tb/dwf_host_model.sv */
// Host serial controller model for the waveform sequencer register port.
// Assumes the bench fills tx_b and calls run(); pins move on falling core edges.
`timescale 1ns/1ns
`default_nettype none
module dwf_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  logic [7:0] tx_b [0:39];
  logic [7:0] rx_b [0:39];

  // Idle: deselected, serial clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Four core cycles per half period gives the 160 ns serial clock
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // One whole frame, MSB first; read data taken late in the high phase
  task automatic run(input int n);
    cs_n = 1'b0;
    half();
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        din = tx_b[b][i];
        half();
        sclk = 1'b1;
        half();
        rx_b[b][i] = dout;
        sclk = 1'b0;
      end
    end
    half();
    cs_n = 1'b1;
    din = ~din; // Released line must not keep a stale level
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_dac_waveform_fifo_sequencer.sv */
// Self-checking bench for the waveform store and step sequencer.
// Assumes the host model owns the serial pins; the bench drives reset and load pins.
`timescale 1ns/1ns
`default_nettype none
module test_dac_waveform_fifo_sequencer;
  logic core_clk, rst, load_pin, mode_a, mode_both;
  logic sclk, cs_n, din, dout, dac_load;
  logic [11:0] dac_out, dac_in;
  logic [11:0] words [0:15];
  logic [11:0] wbuf [0:16];
  logic [11:0] exp_q [$];
  logic [11:0] got_q [$];
  logic [7:0] ctrl;
  int error_cnt, n_compared, cyc, seed_v;

  dwf_sequencer dut_u (.CORE_CLK(core_clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
    .LOAD_PIN(load_pin), .DAC_A_LOAD_PIN_MODE(mode_a), .DAC_BOTH_LOAD_PIN_MODE(mode_both),
    .DAC_OUT(dac_out), .DAC_OUT_LOAD(dac_load));
  dwf_host_model host_u (.clk(core_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // 50 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Log every sequenced load mid-cycle, where the pulse is settled; cut a hang short
  always @(negedge core_clk) begin
    cyc++;
    if (dac_load === 1'b1) got_q.push_back(dac_out);
    if (cyc == 80000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic stop_test();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr_ctrl(input logic [7:0] c);
    host_u.tx_b[0] = {1'b0, dwf_pkg::REG_CTRL};
    host_u.tx_b[1] = c;
    host_u.run(2);
    ctrl = c;
  endtask

  // Low nibble is random: it must be ignored
  task automatic wr_burst(input int n);
    host_u.tx_b[0] = {1'b0, dwf_pkg::REG_WORD_PORT};
    for (int i = 0; i < n; i++) begin
      host_u.tx_b[1 + 2 * i] = wbuf[i][11:4];
      host_u.tx_b[2 + 2 * i] = {wbuf[i][3:0], 4'($urandom)};
      if (ctrl[7] == 1'b0 && i <= ctrl[3:0]) words[i] = wbuf[i];
    end
    host_u.run(1 + 2 * n);
  endtask

  task automatic rd_check();
    host_u.tx_b[0] = {1'b1, dwf_pkg::REG_WORD_PORT};
    host_u.run(33);
    for (int i = 0; i < 16; i++) begin
      check({host_u.rx_b[1 + 2 * i], host_u.rx_b[2 + 2 * i]}, (i <= ctrl[3:0]) ? {words[i], 4'h0} : 16'h0000);
    end
  endtask

  // Pin pulse counts only with a mode set; other steps use the step register
  task automatic step(input int k);
    if (k % 3 == 2) begin
      mode_a = k[0];
      mode_both = ~k[0];
    end
    load_pin = 1'b1;
    repeat (3) @(negedge core_clk);
    load_pin = 1'b0;
    repeat (6) @(negedge core_clk);
    mode_a = 1'b0;
    mode_both = 1'b0;
    if (k % 3 != 2) begin
      host_u.tx_b[0] = {1'b0, dwf_pkg::REG_STEP};
      host_u.tx_b[1] = 8'($urandom);
      host_u.run(2);
    end
  endtask

  // Expected output for location k, sign s, clamped like the adder
  function automatic void push_exp(input int k, input int s);
    int v;
    int r;
    v = 0;
    if (k > 0 && ctrl[6]) v = words[k - 1][11] ? -int'(words[k - 1][10:0]) : int'(words[k - 1][10:0]);
    if (k > 0 && !ctrl[6]) v = int'(words[k - 1]);
    r = int'(dac_in) + s * v;
    exp_q.push_back(r < 0 ? 12'h000 : (r > 4095 ? 12'hFFF : 12'(r)));
  endfunction

  // One waveform period; a repeat of a shape that ends at zero skips the bare input
  function automatic void build(input bit again);
    int n;
    n = int'(ctrl[3:0]) + 1;
    for (int k = (again && (ctrl[5] || ctrl[6])) ? 1 : 0; k <= n; k++) push_exp(k, 1);
    if (ctrl[5]) for (int k = n - 1; k >= 0; k--) push_exp(k, 1);
    if (ctrl[6] && ctrl[5]) begin
      for (int k = 1; k <= n; k++) push_exp(k, -1);
      for (int k = n - 1; k >= 0; k--) push_exp(k, -1);
    end
    if (ctrl[6] && !ctrl[5]) for (int k = n; k >= 0; k--) push_exp(k, -1);
  endfunction

  // Start mid-run under another shape so the control write must restart it
  task automatic run_seq(input logic [7:0] c);
    int steps;
    wr_ctrl(c ^ 8'h20);
    step(0);
    step(1);
    wr_ctrl(c);
    got_q.delete();
    exp_q.delete();
    build(1'b0);
    if (c[4]) build(1'b1);
    steps = exp_q.size() + (c[4] ? 0 : 2);
    for (int k = 0; k < steps; k++) begin
      step(k);
      if (k == 0) begin
        host_u.tx_b[0] = {1'b1, dwf_pkg::REG_STEP};
        host_u.run(3);
        check({host_u.rx_b[1], host_u.rx_b[2]}, 16'h0000);
      end
    end
    check(16'(got_q.size()), 16'(exp_q.size()));
    for (int k = 0; k < exp_q.size() && k < got_q.size(); k++) begin
      check({4'h0, got_q[k]}, {4'h0, exp_q[k]});
    end
  endtask

  initial begin
    int d;
    seed_v = $urandom(64);
    rst = 1'b1;
    load_pin = 1'b0;
    mode_a = 1'b0;
    mode_both = 1'b0;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    check({4'h0, dac_out}, {4'h0, dwf_pkg::DAC_OUT_RESET});
    ctrl = dwf_pkg::CTRL_RESET;
    dac_in = dwf_pkg::DAC_IN_RESET;
    // Disabled sequencer ignores a step
    step(0);
    check(16'(got_q.size()), 16'h0000);
    // Full depth; the seventeenth word has no home
    wr_ctrl(8'h0F);
    for (int i = 0; i < 17; i++) wbuf[i] = 12'($urandom);
    wr_burst(17);
    rd_check();
    // Shorter depth: words past it leave older ones alone
    d = $urandom % 15;
    wr_ctrl(8'(d));
    for (int i = 0; i < 16; i++) wbuf[i] = 12'($urandom);
    wr_burst(16);
    rd_check();
    wr_ctrl(8'h0F);
    rd_check();
    // Writes dropped while enabled, reads still answered
    wr_ctrl(8'h8F);
    for (int i = 0; i < 4; i++) wbuf[i] = 12'($urandom);
    wr_burst(4);
    rd_check();
    // All phase shapes single, then all continuous, full-scale input first for clamping
    for (int j = 0; j < 8; j++) begin
      dac_in = (j == 0) ? dwf_pkg::DAC_FULL_SCALE : 12'($urandom);
      host_u.tx_b[0] = {1'b0, dwf_pkg::REG_DAC_IN};
      host_u.tx_b[1] = dac_in[11:4];
      host_u.tx_b[2] = {dac_in[3:0], 4'h0};
      host_u.run(3);
      run_seq({1'b1, 2'(j), (j >= 4), 4'($urandom % 5)});
    end
    stop_test();
  end
endmodule
`default_nettype wire
